// ==== hw/drive_parameter_register_map.sv ====
module drive_parameter_register_map (
    input  wire logic                  clk_i,    // control clock
    input  wire logic                  rst_b_i,  // async reset, active low
    input  wire drive_param_pkg::req_s req_i,    // register request from framer
    output drive_param_pkg::rsp_s      rsp_o,    // answer, one cycle later
    output drive_param_pkg::param_s    param_o   // stored and decoded settings
);

    logic [31:0]             accel_reg,   accel_next;
    logic [31:0]             decel_reg,   decel_next;
    logic [31:0]             vstart_reg,  vstart_next;
    logic [15:0]             accel_hi_reg, accel_hi_next;
    logic [15:0]             decel_hi_reg, decel_hi_next;
    logic [15:0]             vstart_hi_reg, vstart_hi_next;
    logic [15:0]             dir_reg,     dir_next;
    logic [15:0]             fsrc_reg,    fsrc_next;
    logic [15:0]             rsrc_reg,    rsrc_next;
    logic [15:0]             base_reg,    base_next;
    logic [15:0]             max_reg,     max_next;
    logic [15:0]             asw_reg,     asw_next;
    logic [15:0]             third_reg,   third_next;
    drive_param_pkg::rsp_s   rsp_reg,     rsp_next;
    drive_param_pkg::param_s param_reg,   param_next;
    logic [15:0]             int_addr;
    logic [15:0]             rd_val;
    logic                    hit;
    logic                    ok;
    logic [31:0]             cand;

    always_comb begin
        accel_next     = accel_reg;
        decel_next     = decel_reg;
        vstart_next    = vstart_reg;
        accel_hi_next  = accel_hi_reg;
        decel_hi_next  = decel_hi_reg;
        vstart_hi_next = vstart_hi_reg;
        dir_next       = dir_reg;
        fsrc_next      = fsrc_reg;
        rsrc_next      = rsrc_reg;
        base_next      = base_reg;
        max_next       = max_reg;
        asw_next       = asw_reg;
        third_next     = third_reg;
        rsp_next       = '0;
        rd_val         = '0;
        hit            = 1'b1;
        ok             = 1'b1;
        cand           = '0;
        int_addr = req_i.addr + drive_param_pkg::ADDR_OFFSET;
        case (int_addr)
            drive_param_pkg::REG_ACCEL_HI: begin
                rd_val = accel_reg[31:16];
            end
            drive_param_pkg::REG_ACCEL_LO: begin
                rd_val = accel_reg[15:0];
                cand   = {accel_hi_reg, req_i.wdata};
                ok     = (cand >= drive_param_pkg::RAMP_MIN) &&
                         (cand <= drive_param_pkg::RAMP_MAX);
            end
            drive_param_pkg::REG_DECEL_HI: begin
                rd_val = decel_reg[31:16];
            end
            drive_param_pkg::REG_DECEL_LO: begin
                rd_val = decel_reg[15:0];
                cand   = {decel_hi_reg, req_i.wdata};
                ok     = (cand >= drive_param_pkg::RAMP_MIN) &&
                         (cand <= drive_param_pkg::RAMP_MAX);
            end
            drive_param_pkg::REG_DIRECTION: begin
                rd_val = dir_reg;
                ok     = req_i.wdata <= drive_param_pkg::DIR_MAX;
            end
            drive_param_pkg::REG_FREQ_SRC: begin
                rd_val = fsrc_reg;
                ok     = (req_i.wdata <= drive_param_pkg::FSRC_LAST_LOW) ||
                         (req_i.wdata == drive_param_pkg::FSRC_COMPUTED);
            end
            drive_param_pkg::REG_RUN_SRC: begin
                rd_val = rsrc_reg;
                ok     = (req_i.wdata >= drive_param_pkg::RSRC_MIN) &&
                         (req_i.wdata <= drive_param_pkg::RSRC_MAX);
            end
            drive_param_pkg::REG_BASE_FREQ: begin
                rd_val = base_reg;
                ok     = (req_i.wdata >= drive_param_pkg::FREQ_MIN) &&
                         (req_i.wdata <= max_reg);
            end
            drive_param_pkg::REG_MAX_FREQ: begin
                rd_val = max_reg;
                ok     = (req_i.wdata >= drive_param_pkg::FREQ_MIN) &&
                         (req_i.wdata <= drive_param_pkg::FREQ_LIMIT) &&
                         (req_i.wdata >= base_reg);
            end
            drive_param_pkg::REG_ANALOG_SW: begin
                rd_val = asw_reg;
                ok     = req_i.wdata <= drive_param_pkg::ASW_MAX;
            end
            drive_param_pkg::REG_THIRD_IN: begin
                rd_val = third_reg;
                ok     = req_i.wdata <= drive_param_pkg::THIRD_MAX;
            end
            drive_param_pkg::REG_VSTART_HI: begin
                rd_val = vstart_reg[31:16];
            end
            drive_param_pkg::REG_VSTART_LO: begin
                rd_val = vstart_reg[15:0];
                cand   = {vstart_hi_reg, req_i.wdata};
                ok     = cand <= drive_param_pkg::VSTART_MAX;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (req_i.valid) begin
            rsp_next.valid = 1'b1;
            if (!hit) begin
                rsp_next.exc = drive_param_pkg::EXC_ADDR;
            end else if (!req_i.write) begin
                rsp_next.rdata = rd_val;
            end else if (!ok) begin
                rsp_next.exc = drive_param_pkg::EXC_DATA;
            end else begin
                // high words wait in a holding register so a pair commits whole
                case (int_addr)
                    drive_param_pkg::REG_ACCEL_HI:  accel_hi_next  = req_i.wdata;
                    drive_param_pkg::REG_ACCEL_LO:  accel_next     = cand;
                    drive_param_pkg::REG_DECEL_HI:  decel_hi_next  = req_i.wdata;
                    drive_param_pkg::REG_DECEL_LO:  decel_next     = cand;
                    drive_param_pkg::REG_DIRECTION: dir_next       = req_i.wdata;
                    drive_param_pkg::REG_FREQ_SRC:  fsrc_next      = req_i.wdata;
                    drive_param_pkg::REG_RUN_SRC:   rsrc_next      = req_i.wdata;
                    drive_param_pkg::REG_BASE_FREQ: base_next      = req_i.wdata;
                    drive_param_pkg::REG_MAX_FREQ:  max_next       = req_i.wdata;
                    drive_param_pkg::REG_ANALOG_SW: asw_next       = req_i.wdata;
                    drive_param_pkg::REG_THIRD_IN:  third_next     = req_i.wdata;
                    drive_param_pkg::REG_VSTART_HI: vstart_hi_next = req_i.wdata;
                    drive_param_pkg::REG_VSTART_LO: vstart_next    = cand;
                    default: begin
                    end
                endcase
            end
        end
        param_next.accel_time = accel_next;
        param_next.decel_time = decel_next;
        param_next.volt_start = vstart_next;
        param_next.reverse    = dir_next[0];
        // one-hot source, code 10 on the top bit
        if (fsrc_next == drive_param_pkg::FSRC_COMPUTED) begin
            param_next.freq_src = 9'h100;
        end else begin
            param_next.freq_src = 9'h001 << fsrc_next[2:0];
        end
        param_next.run_src    = 5'h01 << (rsrc_next[2:0] - 3'h1);
        param_next.base_freq  = base_next;
        param_next.max_freq   = max_next;
        param_next.analog_sw  = 5'h01 << asw_next[2:0];
        param_next.third_in   = 4'h1 << third_next[1:0];
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            accel_reg     <= drive_param_pkg::RAMP_RST;
            decel_reg     <= drive_param_pkg::RAMP_RST;
            vstart_reg    <= drive_param_pkg::VSTART_RST;
            accel_hi_reg  <= drive_param_pkg::RAMP_RST[31:16];
            decel_hi_reg  <= drive_param_pkg::RAMP_RST[31:16];
            vstart_hi_reg <= drive_param_pkg::VSTART_RST[31:16];
            dir_reg       <= drive_param_pkg::DIR_RST;
            fsrc_reg      <= drive_param_pkg::FSRC_RST;
            rsrc_reg      <= drive_param_pkg::RSRC_RST;
            base_reg      <= drive_param_pkg::FREQ_RST;
            max_reg       <= drive_param_pkg::FREQ_RST;
            asw_reg       <= drive_param_pkg::ASW_RST;
            third_reg     <= drive_param_pkg::THIRD_RST;
            rsp_reg       <= '0;
            param_reg     <= '{accel_time: drive_param_pkg::RAMP_RST,
                               decel_time: drive_param_pkg::RAMP_RST,
                               reverse:    1'b0,
                               freq_src:   9'h002,
                               run_src:    5'h01,
                               base_freq:  drive_param_pkg::FREQ_RST,
                               max_freq:   drive_param_pkg::FREQ_RST,
                               analog_sw:  5'h01,
                               third_in:   4'h1,
                               volt_start: drive_param_pkg::VSTART_RST};
        end else begin
            accel_reg     <= accel_next;
            decel_reg     <= decel_next;
            vstart_reg    <= vstart_next;
            accel_hi_reg  <= accel_hi_next;
            decel_hi_reg  <= decel_hi_next;
            vstart_hi_reg <= vstart_hi_next;
            dir_reg       <= dir_next;
            fsrc_reg      <= fsrc_next;
            rsrc_reg      <= rsrc_next;
            base_reg      <= base_next;
            max_reg       <= max_next;
            asw_reg       <= asw_next;
            third_reg     <= third_next;
            rsp_reg       <= rsp_next;
            param_reg     <= param_next;
        end
    end

    assign rsp_o   = rsp_reg;
    assign param_o = param_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_ADDR_MAP: assert property (
        req_i.valid && !req_i.write &&
        req_i.addr == (drive_param_pkg::REG_DIRECTION - drive_param_pkg::ADDR_OFFSET)
        |=> rsp_o.valid && rsp_o.exc == drive_param_pkg::EXC_NONE &&
            rsp_o.rdata == $past(dir_reg))
        else $error("direction read at translated address gave wrong answer");

    AST_ACCEL_RANGE: assert property (
        param_o.accel_time >= drive_param_pkg::RAMP_MIN &&
        param_o.accel_time <= drive_param_pkg::RAMP_MAX)
        else $error("acceleration time out of range");

    AST_DECEL_COMMIT: assert property (
        req_i.valid && req_i.write &&
        req_i.addr == (drive_param_pkg::REG_DECEL_LO - drive_param_pkg::ADDR_OFFSET)
        ##1 rsp_o.exc == drive_param_pkg::EXC_NONE
        |-> param_o.decel_time == {$past(decel_hi_reg), $past(req_i.wdata)})
        else $error("deceleration pair did not commit");

    AST_DIRECTION: assert property (
        param_o.reverse == (dir_reg == drive_param_pkg::DIR_MAX))
        else $error("direction output disagrees with register");

    AST_FREQ_SRC: assert property (
        $onehot(param_o.freq_src))
        else $error("frequency source decode not one-hot");

    AST_RUN_SRC: assert property (
        $onehot(param_o.run_src) && rsrc_reg >= drive_param_pkg::RSRC_MIN)
        else $error("run source decode invalid");

    AST_FREQ_LIMITS: assert property (
        param_o.base_freq >= drive_param_pkg::FREQ_MIN &&
        param_o.base_freq <= param_o.max_freq &&
        param_o.max_freq <= drive_param_pkg::FREQ_LIMIT)
        else $error("base or maximum frequency out of limits");

    AST_ANALOG_SW: assert property (
        $onehot(param_o.analog_sw) && asw_reg <= drive_param_pkg::ASW_MAX)
        else $error("analog switching decode invalid");

    AST_THIRD_IN: assert property (
        $onehot(param_o.third_in))
        else $error("third input decode not one-hot");

    AST_VSTART_RANGE: assert property (
        param_o.volt_start <= drive_param_pkg::VSTART_MAX)
        else $error("voltage start frequency out of range");

    AST_UNMAPPED: assert property (
        req_i.valid &&
        (req_i.addr + drive_param_pkg::ADDR_OFFSET) > drive_param_pkg::REG_DIRECTION &&
        (req_i.addr + drive_param_pkg::ADDR_OFFSET) < drive_param_pkg::REG_FREQ_SRC
        |=> rsp_o.valid && rsp_o.exc == drive_param_pkg::EXC_ADDR)
        else $error("unused register number was not refused");

    // the small gap between the selectors and the start frequency pair
    AST_UNMAPPED_GAP: assert property (
        req_i.valid &&
        (req_i.addr + drive_param_pkg::ADDR_OFFSET) > drive_param_pkg::REG_THIRD_IN &&
        (req_i.addr + drive_param_pkg::ADDR_OFFSET) < drive_param_pkg::REG_VSTART_HI
        |=> rsp_o.valid && rsp_o.exc == drive_param_pkg::EXC_ADDR)
        else $error("unused register number in the selector gap was not refused");

    AST_REJECT_KEEPS: assert property (
        req_i.valid && req_i.write && req_i.wdata > drive_param_pkg::FREQ_LIMIT &&
        req_i.addr == (drive_param_pkg::REG_MAX_FREQ - drive_param_pkg::ADDR_OFFSET)
        |=> rsp_o.exc == drive_param_pkg::EXC_DATA && $stable(param_o.max_freq))
        else $error("rejected write changed maximum frequency");

endmodule

// ==== pkg/drive_param_pkg.sv ====
package drive_param_pkg;

    // protocol address plus this offset gives the internal register number
    localparam logic [15:0] ADDR_OFFSET     = 16'h0001;

    localparam logic [15:0] REG_ACCEL_HI    = 16'h1103;
    localparam logic [15:0] REG_ACCEL_LO    = 16'h1104;
    localparam logic [15:0] REG_DECEL_HI    = 16'h1105;
    localparam logic [15:0] REG_DECEL_LO    = 16'h1106;
    localparam logic [15:0] REG_DIRECTION   = 16'h1107;
    localparam logic [15:0] REG_FREQ_SRC    = 16'h1201;
    localparam logic [15:0] REG_RUN_SRC     = 16'h1202;
    localparam logic [15:0] REG_BASE_FREQ   = 16'h1203;
    localparam logic [15:0] REG_MAX_FREQ    = 16'h1204;
    localparam logic [15:0] REG_ANALOG_SW   = 16'h1205;
    localparam logic [15:0] REG_THIRD_IN    = 16'h1206;
    localparam logic [15:0] REG_VSTART_HI   = 16'h120b;
    localparam logic [15:0] REG_VSTART_LO   = 16'h120c;

    // ranges of accepted values
    localparam logic [31:0] RAMP_MIN        = 32'h00000001;
    localparam logic [31:0] RAMP_MAX        = 32'h00057e40;
    localparam logic [31:0] VSTART_MAX      = 32'h00009c40;
    localparam logic [15:0] FREQ_MIN        = 16'h001e;
    localparam logic [15:0] FREQ_LIMIT      = 16'h0190;
    localparam logic [15:0] DIR_MAX         = 16'h0001;
    localparam logic [15:0] FSRC_LAST_LOW   = 16'h0007;
    localparam logic [15:0] FSRC_COMPUTED   = 16'h000a;
    localparam logic [15:0] RSRC_MIN        = 16'h0001;
    localparam logic [15:0] RSRC_MAX        = 16'h0005;
    localparam logic [15:0] ASW_MAX         = 16'h0004;
    localparam logic [15:0] THIRD_MAX       = 16'h0003;

    // reset values
    localparam logic [31:0] RAMP_RST        = 32'h00000bb8;
    localparam logic [31:0] VSTART_RST      = 32'h00000000;
    localparam logic [15:0] DIR_RST         = 16'h0000;
    localparam logic [15:0] FSRC_RST        = 16'h0001;
    localparam logic [15:0] RSRC_RST        = 16'h0001;
    localparam logic [15:0] FREQ_RST        = 16'h003c;
    localparam logic [15:0] ASW_RST         = 16'h0000;
    localparam logic [15:0] THIRD_RST       = 16'h0000;

    // exception codes of the answer
    localparam logic [7:0]  EXC_NONE        = 8'h00;
    localparam logic [7:0]  EXC_ADDR        = 8'h02;
    localparam logic [7:0]  EXC_DATA        = 8'h03;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } req_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] rdata;
        logic [7:0]  exc;
    } rsp_s;

    typedef struct packed {
        logic [31:0] accel_time;
        logic [31:0] decel_time;
        logic        reverse;
        logic [8:0]  freq_src;
        logic [4:0]  run_src;
        logic [15:0] base_freq;
        logic [15:0] max_freq;
        logic [4:0]  analog_sw;
        logic [3:0]  third_in;
        logic [31:0] volt_start;
    } param_s;

endpackage

// ==== verification/modbus_master_model.sv ====
module modbus_master_model (
    input  wire logic                  clk_i,  // control clock
    input  wire drive_param_pkg::rsp_s rsp_i,  // answer from the register bank
    output drive_param_pkg::req_s      req_o   // register request
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req_o = '0;

    // drives on the falling edge; the rising edge in between takes the request
    task automatic access(input  logic        wr,
                          input  logic [15:0] regnum,
                          input  logic [15:0] wd,
                          output logic [15:0] rd,
                          output logic [7:0]  exc,
                          output logic        got);
        got = 1'b0;
        rd  = 16'h0000;
        exc = 8'hff;
        @(negedge clk_i);
        req_o.valid = 1'b1;
        req_o.write = wr;
        req_o.addr  = regnum - 16'h0001;
        req_o.wdata = wd;
        @(negedge clk_i);
        // released lines show the inverse so stale values cannot pass
        req_o.valid = 1'b0;
        req_o.write = ~req_o.write;
        req_o.addr  = ~req_o.addr;
        req_o.wdata = ~req_o.wdata;
        for (int i = 0; i < 3 && !got; i++) begin
            if (rsp_i.valid === 1'b1) begin
                got = 1'b1;
                rd  = rsp_i.rdata;
                exc = rsp_i.exc;
            end else begin
                @(negedge clk_i);
            end
        end
    endtask
endmodule

// ==== verification/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     clk_i;
    logic                     rst_b_i;
    drive_param_pkg::req_s    req;
    drive_param_pkg::rsp_s    rsp;
    drive_param_pkg::param_s  prm;
    int                       n_fail;
    int                       compares;
    logic [15:0]              rd_v;
    logic [7:0]               exc_v;
    logic                     got_v;
    logic [15:0]              regs [13] = '{16'h1103, 16'h1104, 16'h1105, 16'h1106, 16'h1107,
        16'h1201, 16'h1202, 16'h1203, 16'h1204, 16'h1205, 16'h1206, 16'h120b, 16'h120c};
    logic [15:0]              rstv [13] = '{16'h0000, 16'h0bb8, 16'h0000, 16'h0bb8, 16'h0000,
        16'h0001, 16'h0001, 16'h003c, 16'h003c, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0]              bad [7] = '{16'h1102, 16'h1108, 16'h1200, 16'h1207, 16'h120a,
        16'h120d, 16'h0000};

    initial clk_i = 1'b0;
    always #5 clk_i = ~clk_i;

    drive_parameter_register_map u_dut (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .req_i   (req),
        .rsp_o   (rsp),
        .param_o (prm)
    );

    modbus_master_model u_master (
        .clk_i (clk_i),
        .rsp_i (rsp),
        .req_o (req)
    );

    task automatic end_of_test();
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] r, input logic [15:0] d, input logic [7:0] e);
        u_master.access(1'b1, r, d, rd_v, exc_v, got_v);
        chk({31'h0, got_v}, 32'h1, "no answer to write");
        chk({24'h0, exc_v}, {24'h0, e}, "write exception");
    endtask

    task automatic rd(input logic [15:0] r, input logic [15:0] d, input logic [7:0] e);
        u_master.access(1'b0, r, 16'h0000, rd_v, exc_v, got_v);
        chk({31'h0, got_v}, 32'h1, "no answer to read");
        chk({24'h0, exc_v}, {24'h0, e}, "read exception");
        chk({16'h0, rd_v}, {16'h0, d}, "read data");
    endtask

    function automatic logic [31:0] field(input logic [15:0] r);
        case (r)
            16'h1107: field = {31'h0, prm.reverse};
            16'h1201: field = 32'(prm.freq_src);
            16'h1202: field = 32'(prm.run_src);
            16'h1205: field = 32'(prm.analog_sw);
            16'h1206: field = 32'(prm.third_in);
            16'h1103: field = prm.accel_time;
            16'h1105: field = prm.decel_time;
            default:  field = prm.volt_start;
        endcase
    endfunction

    function automatic logic legal(input logic [15:0] r, input logic [15:0] c);
        case (r)
            16'h1107: legal = c <= 16'h0001;
            16'h1201: legal = c <= 16'h0007 || c == 16'h000a;
            16'h1202: legal = c >= 16'h0001 && c <= 16'h0005;
            16'h1205: legal = c <= 16'h0004;
            default:  legal = c <= 16'h0003;
        endcase
    endfunction

    function automatic logic [31:0] onehot(input logic [15:0] r, input logic [15:0] c);
        case (r)
            16'h1107: onehot = 32'(c);
            16'h1201: onehot = (c == 16'h000a) ? 32'h00000100 : 32'h00000001 << c;
            16'h1202: onehot = 32'h00000001 << (c - 16'h0001);
            default:  onehot = 32'h00000001 << c;
        endcase
    endfunction

    // every code 0..11 in turn; rejected codes must leave the last good one standing
    task automatic sweep(input logic [15:0] r, input logic [15:0] start);
        logic [15:0] last;
        logic        ok;
        last = start;
        for (int c = 0; c < 12; c++) begin
            ok = legal(r, 16'(c));
            wr(r, 16'(c), ok ? 8'h00 : 8'h03);
            if (ok) begin
                last = 16'(c);
            end
            rd(r, last, 8'h00);
            chk(field(r), onehot(r, last), "decoded selector");
        end
    endtask

    task automatic w32(input logic [15:0] h, input logic [31:0] v, input logic [7:0] e);
        wr(h, v[31:16], 8'h00);
        wr(h + 16'h0001, v[15:0], e);
    endtask

    // boundaries of a split value; the rejected low bound leaves a stale held high word
    task automatic ramp(input logic [15:0] h, input logic [31:0] lo, input logic [31:0] hi);
        w32(h, hi, 8'h00);
        chk(field(h), hi, "committed upper bound");
        w32(h, hi + 32'h1, 8'h03);
        chk(field(h), hi, "rejected above range");
        if (lo != 32'h0) begin
            w32(h, lo - 32'h1, 8'h03);
        end
        rd(h, hi[31:16], 8'h00);
        rd(h + 16'h0001, hi[15:0], 8'h00);
        w32(h, lo, 8'h00);
        chk(field(h), lo, "committed lower bound");
    endtask

    initial begin
        n_fail   = 0;
        compares = 0;
        rst_b_i  = 1'b0;
        repeat (8) @(negedge clk_i);
        rst_b_i = 1'b1;
        for (int i = 0; i < 13; i++) begin
            rd(regs[i], rstv[i], 8'h00);
        end
        chk(prm.accel_time, 32'h00000bb8, "reset acceleration");
        chk(32'(prm.freq_src), 32'h00000002, "reset frequency source");
        for (int i = 0; i < 7; i++) begin
            rd(bad[i], 16'h0000, 8'h02);
            wr(bad[i], 16'h0001, 8'h02);
        end
        ramp(16'h1103, 32'h00000001, 32'h00057e40);
        ramp(16'h1105, 32'h00000001, 32'h00057e40);
        ramp(16'h120b, 32'h00000000, 32'h00009c40);
        sweep(16'h1107, 16'h0000);
        sweep(16'h1201, 16'h0001);
        sweep(16'h1202, 16'h0001);
        sweep(16'h1205, 16'h0000);
        sweep(16'h1206, 16'h0000);
        wr(16'h1204, 16'h001d, 8'h03);
        wr(16'h1204, 16'h0191, 8'h03);
        wr(16'h1204, 16'h0190, 8'h00);
        wr(16'h1203, 16'h0191, 8'h03);
        wr(16'h1203, 16'h0190, 8'h00);
        wr(16'h1204, 16'h018f, 8'h03);
        wr(16'h1203, 16'h001d, 8'h03);
        chk(32'(prm.base_freq), 32'h00000190, "base at maximum");
        wr(16'h1203, 16'h001e, 8'h00);
        wr(16'h1204, 16'h001e, 8'h00);
        rd(16'h1204, 16'h001e, 8'h00);
        chk(32'(prm.max_freq), 32'h0000001e, "maximum at floor");
        chk(32'(prm.base_freq), 32'h0000001e, "base at floor");
        // a reset in mid-run must bring the settings back
        rst_b_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        rd(16'h1204, 16'h003c, 8'h00);
        chk(32'(prm.base_freq), 32'h0000003c, "base after reset");
        chk(32'(prm.run_src), 32'h00000001, "run source after reset");
        chk(prm.decel_time, 32'h00000bb8, "deceleration after reset");
        end_of_test();
    end

    // the whole sequence needs well under 2000 cycles
    initial begin
        repeat (8000) @(posedge clk_i);
        n_fail++;
        end_of_test();
    end
endmodule
